// file: src/sep_defines.svh
// Constants for the serial EEPROM command and protection front end.
`ifndef SEP_DEFINES_SVH
`define SEP_DEFINES_SVH

// ----------------------------------------------------------------------
// Instruction opcodes
// ----------------------------------------------------------------------
`define SEP_OP_SET_WE 8'h06
`define SEP_OP_CLR_WE 8'h04
`define SEP_OP_RD_STAT 8'h05
`define SEP_OP_WR_STAT 8'h01
`define SEP_OP_RD_ARRAY 8'h03
`define SEP_OP_WR_ARRAY 8'h02

// ----------------------------------------------------------------------
// Status register bit positions and protect codes
// ----------------------------------------------------------------------
`define SEP_SB_PIN_PROT 7
`define SEP_SB_BP_HIGH 3
`define SEP_SB_BP_LOW 2
`define SEP_SB_WE_LATCH 1
`define SEP_SB_BUSY 0
`define SEP_BP_NONE 2'h0
`define SEP_BP_QUARTER 2'h1
`define SEP_BP_HALF 2'h2
`define SEP_BP_FULL 2'h3
`define SEP_STAT_RST 8'h00

// ----------------------------------------------------------------------
// Geometry and timing
// ----------------------------------------------------------------------
`define SEP_ADDR_W_16K 11
`define SEP_PAGE_AW 5
`define SEP_PAGE_BYTES 32
`define SEP_BYTE_LAST 3'h7
`define SEP_ADDR_LAST 4'hf
`define SEP_CLK_MHZ 125
`define SEP_TWC_US 5000
`define SEP_TWC_CYC (`SEP_TWC_US * `SEP_CLK_MHZ)
// Synchronised pin order {wp_n, hold_n, si, cs_n, sck} and its idle level.
`define SEP_PIN_IDLE 5'h1e

`endif

// file: src/sep_pkg.sv
// Types shared by the serial EEPROM front end.
package sep_pkg;
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_OPC,
    ST_ADDR,
    ST_RDATA,
    ST_WDATA,
    ST_STAT_OUT,
    ST_STAT_IN,
    ST_TAIL,
    ST_IGNORE
  } sep_state_e;
endpackage : sep_pkg

// file: src/sep_sync.sv
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/100ps
module sep_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Pins in, synchronised levels out
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_r;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_r <= INIT;
      o_sync <= INIT;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule : sep_sync

// file: src/sep_top.sv
// Serial EEPROM slave: opcode decode, status/protect register, page write, array.
`timescale 1ns/100ps
`include "sep_defines.svh"
module sep_top #(
  parameter int ADDR_W = `SEP_ADDR_W_16K,
  parameter int unsigned WR_CYCLES = `SEP_TWC_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Serial link pins
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic i_hold_n,
  input wire logic i_wp_n,
  // Serial output and its enable
  output logic o_so,
  output logic o_so_oe
);
  localparam int CW = $clog2(WR_CYCLES + 1);
  localparam int PA = `SEP_PAGE_AW;

  // --------------------------------------------------------------------
  // Pin synchronisation and edge detection
  // --------------------------------------------------------------------
  logic [4:0] pin_s;
  logic sck_d_r;
  logic cs_d_r;

  sep_sync #(.W(5), .INIT(`SEP_PIN_IDLE)) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_wp_n, i_hold_n, i_si, i_cs_n, i_sck}),
    .o_sync(pin_s)
  );

  wire sck_s = pin_s[0];
  wire cs_s = pin_s[1];
  wire si_s = pin_s[2];
  wire hold_s = pin_s[3];
  wire wp_s = pin_s[4];
  wire active = !cs_s && hold_s;
  wire rise_ev = active && sck_s && !sck_d_r;
  wire fall_ev = active && !sck_s && sck_d_r;
  wire cs_fall = !cs_s && cs_d_r;
  wire cs_rise = cs_s && !cs_d_r;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      sck_d_r <= sck_s;
      cs_d_r <= cs_s;
    end
  end

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  // Array, page buffer and the non-volatile status bits are not cleared by
  // reset in a real part; here reset zeroes only the status bits.
  logic [7:0] mem_r [0:(1 << ADDR_W)-1];
  logic [7:0] page_r [0:`SEP_PAGE_BYTES-1];
  logic [`SEP_PAGE_BYTES-1:0] mask_r;
  logic [ADDR_W-1:0] page_base_r;
  logic [PA-1:0] page_idx_r;
  logic [ADDR_W-1:0] rd_ptr_r;
  logic [PA:0] prog_idx_r;

  logic pin_prot_r;
  logic [1:0] bp_r;
  logic wel_r;
  logic busy_r;
  logic [CW-1:0] wc_cnt_r;
  logic wp_low_seen_r;

  wire [7:0] status = {pin_prot_r, 3'h0, bp_r, wel_r, busy_r};

  // --------------------------------------------------------------------
  // Shifting and decode
  // --------------------------------------------------------------------
  sep_pkg::sep_state_e state_r;
  sep_pkg::sep_state_e state_nxt;
  logic [7:0] opc_r;
  logic [15:0] in_sr_r;
  logic [3:0] bit_cnt_r;
  logic [3:0] bit_cnt_nxt;
  logic [7:0] out_sr_r;

  wire [15:0] in_word = {in_sr_r[14:0], si_s};
  wire byte_done = rise_ev && (bit_cnt_r[2:0] == `SEP_BYTE_LAST);
  wire addr_done = rise_ev && (bit_cnt_r == `SEP_ADDR_LAST);
  wire [7:0] opc_in = in_word[7:0];
  wire opc_done = byte_done && (state_r == sep_pkg::ST_OPC);
  wire op_rd = opc_r == `SEP_OP_RD_ARRAY;
  wire [ADDR_W-1:0] addr_in = in_word[ADDR_W-1:0];
  wire [ADDR_W-1:0] load_addr = {page_base_r[ADDR_W-1:PA], page_idx_r};
  wire [ADDR_W-1:0] prog_addr = {page_base_r[ADDR_W-1:PA], prog_idx_r[PA-1:0]};

  function automatic logic in_prot(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
    case (bp)
      `SEP_BP_QUARTER: in_prot = &a[ADDR_W-1:ADDR_W-2];
      `SEP_BP_HALF: in_prot = a[ADDR_W-1];
      `SEP_BP_FULL: in_prot = 1'b1;
      default: in_prot = 1'b0;
    endcase
  endfunction : in_prot

  always_comb begin
    state_nxt = state_r;
    bit_cnt_nxt = rise_ev ? bit_cnt_r + 4'h1 : bit_cnt_r;
    case (state_r)
      sep_pkg::ST_IDLE: begin
        bit_cnt_nxt = 4'h0;
      end
      sep_pkg::ST_OPC: begin
        if (opc_done) begin
          bit_cnt_nxt = 4'h0;
          if (busy_r && opc_in != `SEP_OP_RD_STAT) begin
            state_nxt = sep_pkg::ST_IGNORE;
          end else begin
            case (opc_in)
              `SEP_OP_SET_WE: state_nxt = sep_pkg::ST_TAIL;
              `SEP_OP_CLR_WE: state_nxt = sep_pkg::ST_TAIL;
              `SEP_OP_RD_STAT: state_nxt = sep_pkg::ST_STAT_OUT;
              `SEP_OP_WR_STAT: state_nxt = sep_pkg::ST_STAT_IN;
              `SEP_OP_RD_ARRAY: state_nxt = sep_pkg::ST_ADDR;
              `SEP_OP_WR_ARRAY: state_nxt = sep_pkg::ST_ADDR;
              default: state_nxt = sep_pkg::ST_IGNORE;
            endcase
          end
        end
      end
      sep_pkg::ST_ADDR: begin
        if (addr_done) begin
          state_nxt = op_rd ? sep_pkg::ST_RDATA : sep_pkg::ST_WDATA;
        end
      end
      sep_pkg::ST_STAT_IN: begin
        if (byte_done) begin
          state_nxt = sep_pkg::ST_TAIL;
        end
      end
      sep_pkg::ST_TAIL: begin
        // Any extra clock after a complete instruction spoils the session.
        if (rise_ev) begin
          state_nxt = sep_pkg::ST_IGNORE;
        end
      end
      sep_pkg::ST_RDATA, sep_pkg::ST_WDATA, sep_pkg::ST_STAT_OUT,
      sep_pkg::ST_IGNORE: begin
        state_nxt = state_r;
      end
      default: state_nxt = sep_pkg::ST_IDLE;
    endcase
    if (cs_s) begin
      state_nxt = sep_pkg::ST_IDLE;
    end else if (cs_fall) begin
      state_nxt = sep_pkg::ST_OPC;
      bit_cnt_nxt = 4'h0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_r <= sep_pkg::ST_IDLE;
      bit_cnt_r <= 4'h0;
      opc_r <= 8'h00;
      in_sr_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      if (rise_ev) begin
        in_sr_r <= in_word;
      end
      if (opc_done) begin
        opc_r <= opc_in;
      end
    end
  end

  // --------------------------------------------------------------------
  // Commit points at the end of a session
  // --------------------------------------------------------------------
  // Pin protection also trips if the pin dropped at any time in the session.
  wire wp_lock = pin_prot_r && (wp_low_seen_r || !wp_s);
  wire in_tail = state_r == sep_pkg::ST_TAIL;
  wire set_we_go = cs_rise && in_tail && opc_r == `SEP_OP_SET_WE;
  wire clr_we_go = cs_rise && in_tail && opc_r == `SEP_OP_CLR_WE;
  wire wr_stat_go = cs_rise && in_tail && opc_r == `SEP_OP_WR_STAT && wel_r && !wp_lock;
  wire wr_arr_go = cs_rise && state_r == sep_pkg::ST_WDATA && bit_cnt_r[2:0] == 3'h0
                   && |mask_r && wel_r;
  wire wc_start = wr_stat_go || wr_arr_go;
  wire wc_end = busy_r && wc_cnt_r == CW'(1);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wp_low_seen_r <= 1'b0;
    end else if (cs_s) begin
      wp_low_seen_r <= 1'b0;
    end else if (!wp_s) begin
      wp_low_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wel_r <= 1'(`SEP_STAT_RST >> `SEP_SB_WE_LATCH);
      pin_prot_r <= 1'(`SEP_STAT_RST >> `SEP_SB_PIN_PROT);
      bp_r <= `SEP_BP_NONE;
    end else begin
      if (set_we_go) begin
        wel_r <= 1'b1;
      end else if (clr_we_go || wc_end) begin
        wel_r <= 1'b0;
      end
      if (wr_stat_go) begin
        pin_prot_r <= in_sr_r[`SEP_SB_PIN_PROT];
        bp_r <= in_sr_r[`SEP_SB_BP_HIGH:`SEP_SB_BP_LOW];
      end
    end
  end

  // --------------------------------------------------------------------
  // Self-timed write cycle
  // --------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      busy_r <= 1'b0;
      wc_cnt_r <= '0;
    end else if (wc_start) begin
      busy_r <= 1'b1;
      wc_cnt_r <= CW'(WR_CYCLES);
    end else if (busy_r) begin
      wc_cnt_r <= wc_cnt_r - CW'(1);
      busy_r <= !wc_end;
    end
  end

  // Programming copies one buffered byte per cycle, so the write cycle
  // must last at least one page worth of cycles.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      prog_idx_r <= (PA+1)'(`SEP_PAGE_BYTES);
    end else if (wr_arr_go) begin
      prog_idx_r <= '0;
    end else if (busy_r && !prog_idx_r[PA]) begin
      prog_idx_r <= prog_idx_r + (PA+1)'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (busy_r && !prog_idx_r[PA] && mask_r[prog_idx_r[PA-1:0]]) begin
      mem_r[prog_addr] <= page_r[prog_idx_r[PA-1:0]];
    end
  end

  // --------------------------------------------------------------------
  // Page loading
  // --------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mask_r <= '0;
      page_base_r <= '0;
      page_idx_r <= '0;
    end else if (addr_done && state_r == sep_pkg::ST_ADDR && !op_rd) begin
      mask_r <= '0;
      page_base_r <= addr_in;
      page_idx_r <= addr_in[PA-1:0];
    end else if (byte_done && state_r == sep_pkg::ST_WDATA) begin
      if (!in_prot(load_addr, bp_r)) begin
        mask_r[page_idx_r] <= 1'b1;
      end
      page_idx_r <= page_idx_r + PA'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (byte_done && state_r == sep_pkg::ST_WDATA) begin
      page_r[page_idx_r] <= in_word[7:0];
    end
  end

  // --------------------------------------------------------------------
  // Output shifting
  // --------------------------------------------------------------------
  wire rd_start = addr_done && state_r == sep_pkg::ST_ADDR && op_rd;
  wire rd_next = byte_done && state_r == sep_pkg::ST_RDATA;
  wire st_load = (opc_done && opc_in == `SEP_OP_RD_STAT && state_nxt == sep_pkg::ST_STAT_OUT)
                 || (byte_done && state_r == sep_pkg::ST_STAT_OUT);
  wire out_phase = state_r == sep_pkg::ST_RDATA || state_r == sep_pkg::ST_STAT_OUT;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rd_ptr_r <= '0;
      out_sr_r <= 8'h00;
      o_so <= 1'b0;
      o_so_oe <= 1'b0;
    end else begin
      o_so_oe <= active && out_phase;
      if (rd_start) begin
        out_sr_r <= mem_r[addr_in];
        rd_ptr_r <= addr_in + ADDR_W'(1);
      end else if (rd_next) begin
        out_sr_r <= mem_r[rd_ptr_r];
        rd_ptr_r <= rd_ptr_r + ADDR_W'(1);
      end else if (st_load) begin
        out_sr_r <= status;
      end else if (fall_ev) begin
        out_sr_r <= {out_sr_r[6:0], 1'b0};
      end
      if (fall_ev && out_phase) begin
        o_so <= out_sr_r[7];
      end
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  so_off_idle_a: assert property (cs_s |=> !o_so_oe)
    else $error("serial output driven while deselected");
  so_off_hold_a: assert property (!hold_s |=> !o_so_oe)
    else $error("serial output driven during hold");
  so_fall_only_a: assert property ($changed(o_so) |-> $past(fall_ev))
    else $error("serial output changed without clock fall");
  latch_reset_a: assert property (@(posedge i_clk) disable iff (1'b0)
    !i_rst_n |=> !wel_r)
    else $error("write latch not cleared by reset");
  latch_set_a: assert property (set_we_go |=> wel_r && !busy_r)
    else $error("write latch not set after clean enable session");
  busy_ignore_a: assert property (busy_r && opc_done && opc_in != `SEP_OP_RD_STAT
    |=> state_r == sep_pkg::ST_IGNORE)
    else $error("instruction accepted during write cycle");
  cycle_end_a: assert property (wc_end |=> !busy_r && !wel_r)
    else $error("write cycle end left busy or latch set");
  cycle_start_a: assert property (wc_start |=> busy_r ##1 busy_r)
    else $error("write cycle did not start on select rise");
  stat_locked_a: assert property (cs_rise && in_tail && opc_r == `SEP_OP_WR_STAT
    && wp_lock |=> $stable(bp_r) && $stable(pin_prot_r) && !busy_r)
    else $error("status written while pin protected");
  bad_opc_a: assert property (opc_done && state_nxt == sep_pkg::ST_IGNORE
    |=> !o_so_oe [*2])
    else $error("output driven after ignored opcode");
endmodule : sep_top

// file: verification/sep_host_model.sv
// Host serial master model that drives the EEPROM pins in mode 0 or mode 3.
`timescale 1ns/100ps
module sep_host_model (
  // Clock
  input wire logic i_clk,
  // Serial link pins
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si,
  output logic o_hold_n,
  output logic o_wp_n,
  input wire logic i_so,
  input wire logic i_so_oe
);
  // ----------------------------------------------------------------------
  // Pin drive and sampling
  // ----------------------------------------------------------------------
  logic so_last;
  logic so_line;
  logic oe_seen;
  int edge_errs;
  logic cpol;

  // A released output has no pull, so it reads as the inverse of its last level.
  assign so_line = i_so_oe ? i_so : ~so_last;

  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
    o_hold_n = 1'b1;
    o_wp_n = 1'b1;
    so_last = 1'b0;
    oe_seen = 1'b0;
    edge_errs = 0;
    cpol = 1'b0;
  end

  always @(posedge i_clk) begin
    if (i_so_oe === 1'b1) begin
      so_last <= i_so;
      oe_seen <= 1'b1;
    end
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge i_clk);
  endtask : wait_clk

  task automatic set_wp(input logic v);
    o_wp_n = v;
    wait_clk(2);
  endtask : set_wp

  // Only called while deselected, so the idle level change is no clock edge.
  task automatic set_mode(input logic v);
    cpol = v;
    o_sck = v;
    wait_clk(2);
  endtask : set_mode

  task automatic sess_begin();
    o_cs_n = 1'b0;
    oe_seen = 1'b0;
    wait_clk(3);
  endtask : sess_begin

  task automatic sess_end();
    wait_clk(5);
    o_cs_n = 1'b1;
    wait_clk(8);
  endtask : sess_end

  // The output is sampled twice in each high phase; a change there is counted.
  task automatic xfer(input logic [7:0] tx, input int hold_at, output logic [7:0] rx);
    logic first;
    logic first_oe;
    for (int i = 7; i >= 0; i--) begin
      // In mode 3 the clock idles high, so each bit opens with its fall.
      if (cpol) begin
        o_sck = 1'b0;
      end
      if (i == hold_at) begin
        wait_clk(2);
        o_hold_n = 1'b0;
        wait_clk(20);
        o_hold_n = 1'b1;
        wait_clk(3);
      end
      o_si = tx[i];
      wait_clk(5);
      o_sck = 1'b1;
      wait_clk(1);
      first = so_line;
      first_oe = i_so_oe;
      wait_clk(4);
      rx[i] = so_line;
      if (first_oe === 1'b1 && i_so_oe === 1'b1 && first !== rx[i]) begin
        edge_errs++;
      end
      if (!cpol) begin
        o_sck = 1'b0;
      end
    end
  endtask : xfer
endmodule : sep_host_model

// file: verification/sep_top_tb.sv
// Self-checking bench for the serial EEPROM command and protection front end.
`timescale 1ns/100ps
module sep_top_tb;
  // ----------------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------------
  logic clk;
  logic rst_n;
  logic sck;
  logic cs_n;
  logic si;
  logic hold_n;
  logic wp_n;
  logic so;
  logic so_oe;
  logic [7:0] rxq[$];
  int fails;
  int check_count;
  int cs_hi;

  sep_host_model i_host (
    .i_clk(clk),
    .o_sck(sck),
    .o_cs_n(cs_n),
    .o_si(si),
    .o_hold_n(hold_n),
    .o_wp_n(wp_n),
    .i_so(so),
    .i_so_oe(so_oe)
  );

  // A short write cycle keeps the run brief while outlasting a command session.
  sep_top #(.ADDR_W(11), .WR_CYCLES(400)) i_dut (
    .i_clk(clk),
    .i_rst_n(rst_n),
    .i_sck(sck),
    .i_cs_n(cs_n),
    .i_si(si),
    .i_hold_n(hold_n),
    .i_wp_n(wp_n),
    .o_so(so),
    .o_so_oe(so_oe)
  );

  always #4 clk = ~clk;

  always @(negedge clk) begin
    cs_hi <= (cs_n === 1'b1) ? cs_hi + 1 : 0;
    if (cs_hi > 6 && so_oe !== 1'b0) begin
      fails++;
      $display("MISMATCH so_oe_idle expected 0 seen %b", so_oe);
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic sess(input logic [7:0] q[$], input int hold_at = 9);
    logic [7:0] rx;
    rxq.delete();
    i_host.sess_begin();
    foreach (q[k]) begin
      i_host.xfer(q[k], (k == 0 || k == q.size() - 1) ? hold_at : 9, rx);
      rxq.push_back(rx);
    end
    i_host.sess_end();
  endtask : sess

  task automatic st_is(input logic [7:0] exp);
    sess('{8'h05, 8'h00});
    chk("status", exp, rxq[1]);
  endtask : st_is

  task automatic wait_ready();
    for (int n = 0; n < 8; n++) begin
      sess('{8'h05, 8'h00});
      if (rxq[1][0] === 1'b0) begin
        return;
      end
    end
    fails++;
    $display("MISMATCH ready_wait expected 0 seen 1");
    final_report();
  endtask : wait_ready

  initial begin
    #400000;
    fails++;
    $display("MISMATCH run_time expected end seen hang");
    final_report();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    fails = 0;
    check_count = 0;
    cs_hi = 0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    sess('{8'h05, 8'h00, 8'h00}, 3);
    chk("status_reset", 8'h00, rxq[1]);
    chk("status_repeat", 8'h00, rxq[2]);
    sess('{8'hff, 8'h00, 8'h00});
    chk("oe_bad_opcode", 8'h00, {7'h0, i_host.oe_seen});
    sess('{8'h02, 8'h00, 8'h10, 8'h5a});
    st_is(8'h00);
    sess('{8'h06, 8'h00});
    st_is(8'h00);
    sess('{8'h06});
    st_is(8'h02);
    sess('{8'h04});
    st_is(8'h00);
    sess('{8'h06});
    sess('{8'h02, 8'hf8, 8'h1e, 8'ha0, 8'ha1, 8'ha2, 8'ha3});
    st_is(8'h03);
    wait_ready();
    st_is(8'h00);
    sess('{8'h03, 8'h00, 8'h1e, 8'h00, 8'h00});
    chk("rd_1e", 8'ha0, rxq[3]);
    chk("rd_1f", 8'ha1, rxq[4]);
    sess('{8'h03, 8'h07, 8'hff, 8'h00, 8'h00, 8'h00});
    chk("rd_wrap0", 8'ha2, rxq[4]);
    chk("rd_wrap1", 8'ha3, rxq[5]);
    sess('{8'h06});
    sess('{8'h01, 8'hf5});
    sess('{8'h01, 8'h0c});
    wait_ready();
    st_is(8'h84);
    sess('{8'h06});
    sess('{8'h02, 8'h06, 8'h00, 8'h11});
    st_is(8'h86);
    sess('{8'h02, 8'h05, 8'hff, 8'h3c});
    st_is(8'h87);
    wait_ready();
    sess('{8'h03, 8'h05, 8'hff, 8'h00});
    chk("rd_5ff", 8'h3c, rxq[3]);
    i_host.set_wp(1'b0);
    sess('{8'h06});
    sess('{8'h01, 8'h00});
    st_is(8'h86);
    i_host.set_wp(1'b1);
    sess('{8'h01, 8'h00});
    wait_ready();
    st_is(8'h00);
    i_host.set_mode(1'b1);
    st_is(8'h00);
    sess('{8'h06});
    st_is(8'h02);
    sess('{8'h03, 8'h05, 8'hff, 8'h00});
    chk("rd_5ff_mode3", 8'h3c, rxq[3]);
    // A reset in mid-run must drop the write latch that was just set.
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    st_is(8'h00);
    chk("so_edge_errs", 8'h00, (i_host.edge_errs == 0) ? 8'h00 : 8'hff);
    final_report();
  end
endmodule : sep_top_tb
